// ==== blsr_core.sv ====
// Our own choices: the placing of the registers and the APB interface to the registers.
`default_nettype none

module blsr_core
  import blsr_pkg::*;
#(
  parameter int unsigned RETRY_LIMIT = blsr_pkg::RETRY_LIMIT_DFLT
) (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // apb
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  // pins, active low, except o_s_lock_oe, which is an active-high drive enable
  input  wire logic        i_secondary_system_error_in_n,
  input  wire logic        i_p_lock_n,
  input  wire logic        i_p_frame_n,
  input  wire logic        i_s_lock_n,
  input  wire logic        i_s_frame_n,
  input  wire logic        i_s_irdy_n,
  output logic             o_primary_system_error_out_n,
  output logic             o_s_lock_out,
  output logic             o_s_lock_oe,
  // primary target side events
  input  wire logic        i_lock_req,
  input  wire logic        i_lock_req_read,
  input  wire logic        i_up_req,
  input  wire logic [31:0] i_req_addr,
  input  wire logic [3:0]  i_req_cmd,
  input  wire logic [3:0]  i_req_be,
  input  wire logic        i_req_par,
  input  wire logic        i_rep_valid,
  input  wire logic        i_prior_empty,
  input  wire logic        i_pw_pending,
  // secondary master side events
  input  wire logic        i_sec_data_done,
  input  wire logic        i_sec_retry,
  input  wire logic        i_sec_abort,
  input  wire logic        i_sec_abort_master,
  input  wire logic        i_master_timeout,
  input  wire logic        i_lpw_end,
  input  wire logic        i_pw_retry,
  input  wire logic        i_pw_done,
  input  wire logic        i_pw_target_abort,
  input  wire logic        i_pw_master_abort,
  input  wire logic        i_pw_locked,
  input  wire logic        i_dw_retry,
  input  wire logic        i_dw_done,
  input  wire logic        i_dr_retry,
  input  wire logic        i_dr_done,
  // answers
  output logic             o_tgt_retry,
  output logic             o_tgt_abort,
  output logic             o_read_return,
  output logic             o_queue_hold,
  output logic             o_fwd_locked,
  output logic             o_no_prefetch,
  output logic             o_up_unlocked,
  output logic             o_lrd_start,
  output logic [31:0]      o_lrd_addr,
  output logic [3:0]       o_lrd_cmd,
  output logic [3:0]       o_lrd_be,
  output logic             o_lrd_par,
  output logic             o_pw_discard,
  output logic             o_dw_discard,
  output logic             o_dr_discard,
  output logic             o_lrd_discard
);

  typedef struct packed {
    blsr_lock_type     fsm;
    logic              first;
    logic              lock_drv;
    logic [31:0]       addr;
    logic [3:0]        cmd;
    logic [3:0]        be;
    logic              par;
    logic              tgt_retry;
    logic              tgt_abort;
    logic              read_return;
    logic              lrd_start;
    logic              up_unlocked;
    logic              pw_disc;
    logic              dw_disc;
    logic              dr_disc;
    logic              lrd_disc;
    logic              hold;
    logic              flk;
    logic              serr_n;
    logic              s_serr_seen;
    logic [CNT_W-1:0]  cnt_pw;
    logic [CNT_W-1:0]  cnt_dw;
    logic [CNT_W-1:0]  cnt_dr;
    logic              serr_en;
    logic              sig_serr;
    logic              sig_ta;
    logic              fwd_en;
    logic              ma_mode;
    logic              mto_en;
    logic              rcv_serr;
    logic              rcv_ta;
    logic              rcv_ma;
    logic [DIS_W-1:0]  dis;
    logic [EVT_W-1:0]  reason;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } blsr_state_type;

  localparam logic [CNT_W-1:0] LIMIT_M1 = CNT_W'(RETRY_LIMIT - 1);

  blsr_state_type r;
  blsr_state_type next_r;
  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] pin_q;

  assign pins = {i_s_irdy_n, i_s_frame_n, i_s_lock_n,
                 i_p_frame_n, i_p_lock_n, i_secondary_system_error_in_n};

  blsr_sync u_sync (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_pins    (pins),
    .i_rst_val ('1),
    .o_stable  (pin_q)
  );

  // retry counter step: bit CNT_W is the limit hit
  function automatic logic [CNT_W:0] retry_step(input logic [CNT_W-1:0] cnt,
                                                input logic retry,
                                                input logic done);
    logic [CNT_W:0] res;
    res = {1'b0, cnt};
    if (done) begin
      res = '0;
    end else if (retry) begin
      if (cnt >= LIMIT_M1) begin
        res = {1'b1, {CNT_W{1'b0}}};
      end else begin
        res = {1'b0, cnt + CNT_W'(1)};
      end
    end
    return res;
  endfunction

  function automatic logic w1c(input logic cur, input logic set,
                               input logic clr);
    // a set in the clearing cycle wins
    return set | (cur & ~clr);
  endfunction

  logic [CNT_W:0]  st_pw;
  logic [CNT_W:0]  st_dw;
  logic [CNT_W:0]  st_dr;
  logic [EVT_W-1:0] ev;
  logic            rep_match;
  logic            s_bus_idle;
  logic            s_serr_now;
  logic            wr_acc;
  logic            set_ta;
  logic            set_rta;
  logic            set_rma;
  logic            mto_fire;

  always_comb begin
    next_r = r;
    next_r.tgt_retry   = 1'b0;
    next_r.tgt_abort   = 1'b0;
    next_r.read_return = 1'b0;
    next_r.lrd_start   = 1'b0;
    next_r.up_unlocked = 1'b0;
    next_r.lrd_disc    = 1'b0;
    next_r.serr_n      = 1'b1;
    set_ta   = 1'b0;
    set_rta  = 1'b0;
    set_rma  = 1'b0;
    mto_fire = 1'b0;

    st_pw = retry_step(r.cnt_pw, i_pw_retry, i_pw_done);
    st_dw = retry_step(r.cnt_dw, i_dw_retry, i_dw_done);
    st_dr = retry_step(r.cnt_dr, i_dr_retry, i_dr_done);
    next_r.cnt_pw  = st_pw[CNT_W-1:0];
    next_r.cnt_dw  = st_dw[CNT_W-1:0];
    next_r.cnt_dr  = st_dr[CNT_W-1:0];
    next_r.pw_disc = st_pw[CNT_W];
    next_r.dw_disc = st_dw[CNT_W];
    next_r.dr_disc = st_dr[CNT_W];

    rep_match  = i_rep_valid && (i_req_addr == r.addr) && (i_req_cmd == r.cmd)
                 && (i_req_be == r.be);
    s_bus_idle = pin_q[PIN_S_FRAME] && pin_q[PIN_S_IRDY];
    // upstream lock state is never looked at
    next_r.up_unlocked = i_up_req;

    case (r.fsm)
      LK_IDLE: begin
        // a secondary-only lock never reaches this machine
        if (i_lock_req && i_lock_req_read) begin
          next_r.addr      = i_req_addr;
          next_r.cmd       = i_req_cmd;
          next_r.be        = i_req_be;
          next_r.par       = i_req_par;
          next_r.tgt_retry = 1'b1;
          next_r.first     = 1'b1;
          next_r.fsm       = LK_QUEUED;
        end
      end
      LK_QUEUED: begin
        next_r.tgt_retry = i_rep_valid;
        if (i_prior_empty) begin
          next_r.fsm = LK_WAITBUS;
        end
      end
      LK_WAITBUS: begin
        next_r.tgt_retry = i_rep_valid;
        if (pin_q[PIN_S_LOCK] && s_bus_idle) begin
          next_r.lrd_start = 1'b1;
          next_r.fsm       = LK_ADDR;
        end
      end
      LK_ADDR: begin
        next_r.tgt_retry = i_rep_valid;
        next_r.lock_drv  = 1'b1;
        next_r.fsm       = LK_DATA;
      end
      LK_DATA: begin
        next_r.tgt_retry = i_rep_valid;
        if (i_sec_abort) begin
          next_r.lock_drv = 1'b0;
          set_rta         = ~i_sec_abort_master;
          set_rma         = i_sec_abort_master;
          next_r.fsm      = LK_ABORTED;
        end else if (i_sec_data_done) begin
          next_r.first = 1'b0;
          next_r.fsm   = LK_SECLK;
        end else if (i_sec_retry && r.first) begin
          next_r.lock_drv = 1'b0;
          next_r.fsm      = LK_WAITBUS;
        end
      end
      LK_SECLK: begin
        if (i_master_timeout) begin
          mto_fire         = 1'b1;
          next_r.lock_drv  = 1'b0;
          next_r.lrd_disc  = 1'b1;
          next_r.fsm       = LK_IDLE;
        end else if (rep_match) begin
          next_r.read_return = 1'b1;
          next_r.fsm         = LK_LOCKED;
        end else begin
          next_r.tgt_retry = i_rep_valid;
        end
      end
      LK_LOCKED: begin
        // a retry here leaves the lock held
        if (i_lpw_end && pin_q[PIN_P_LOCK]) begin
          next_r.lock_drv = 1'b0;
          next_r.fsm      = LK_IDLE;
        end else if (pin_q[PIN_P_LOCK] && pin_q[PIN_P_FRAME] && !i_pw_pending) begin
          next_r.lock_drv = 1'b0;
          next_r.fsm      = LK_IDLE;
        end
      end
      LK_ABORTED: begin
        if (rep_match) begin
          next_r.tgt_abort = 1'b1;
          set_ta           = 1'b1;
          next_r.fsm       = LK_IDLE;
        end else if (i_master_timeout) begin
          mto_fire = 1'b1;
          next_r.fsm = LK_IDLE;
        end else begin
          next_r.tgt_retry = i_rep_valid;
        end
      end
      default: begin
        next_r.lock_drv = 1'b0;
        next_r.fsm      = LK_IDLE;
      end
    endcase
    // new locked requests are refused while the machine is busy, except in LK_LOCKED
    if (i_lock_req && (r.fsm != LK_IDLE) && (r.fsm != LK_LOCKED)) begin
      next_r.tgt_retry = 1'b1;
    end
    next_r.hold = (next_r.fsm != LK_IDLE);
    next_r.flk  = (next_r.fsm == LK_LOCKED);

    // system error events; only the secondary serr is forwarded on its assertion edge alone
    s_serr_now         = ~pin_q[PIN_S_SERR];
    next_r.s_serr_seen = s_serr_now;
    ev = '0;
    ev[EV_SEC_SERR] = s_serr_now && !r.s_serr_seen && r.fwd_en;
    ev[EV_PW_TA]    = i_pw_target_abort && (i_pw_locked || !r.dis[0]);
    ev[EV_PW_MA]    = i_pw_master_abort && r.ma_mode
                      && (i_pw_locked || !r.dis[1]);
    ev[EV_PW_DISC]  = next_r.pw_disc && !r.dis[2];
    ev[EV_DW_DISC]  = next_r.dw_disc && !r.dis[3];
    ev[EV_DR_DISC]  = next_r.dr_disc && !r.dis[4];
    ev[EV_MTO]      = (mto_fire || (i_master_timeout && r.fsm == LK_IDLE))
                      && r.mto_en;
    if (!r.serr_en) begin
      ev = '0;
    end
    if (|ev) begin
      next_r.serr_n = 1'b0;
    end

    // apb: registered answer, one wait-free access phase
    wr_acc = i_psel && i_penable && r.pready && i_pwrite;
    next_r.pready  = i_psel && !i_penable;
    next_r.pslverr = 1'b0;
    if (wr_acc) begin
      case (i_paddr)
        ADDR_CMD_STATUS: next_r.serr_en = i_pwdata[BIT_SERR_EN];
        ADDR_BRIDGE_CTL: begin
          next_r.fwd_en  = i_pwdata[BIT_FWD_EN];
          next_r.ma_mode = i_pwdata[BIT_MA_MODE];
          next_r.mto_en  = i_pwdata[BIT_MTO_EN];
        end
        ADDR_EVT_DIS: next_r.dis = i_pwdata[DIS_W-1:0];
        default: begin
        end
      endcase
    end
    next_r.sig_serr = w1c(r.sig_serr, |ev,
      wr_acc && i_paddr == ADDR_CMD_STATUS && i_pwdata[BIT_SIG_SERR]);
    next_r.sig_ta = w1c(r.sig_ta, set_ta,
      wr_acc && i_paddr == ADDR_CMD_STATUS && i_pwdata[BIT_SIG_TA]);
    next_r.rcv_serr = w1c(r.rcv_serr, ev[EV_SEC_SERR],
      wr_acc && i_paddr == ADDR_SEC_STATUS && i_pwdata[BIT_RCV_SERR]);
    next_r.rcv_ta = w1c(r.rcv_ta, set_rta,
      wr_acc && i_paddr == ADDR_SEC_STATUS && i_pwdata[BIT_RCV_TA]);
    next_r.rcv_ma = w1c(r.rcv_ma, set_rma,
      wr_acc && i_paddr == ADDR_SEC_STATUS && i_pwdata[BIT_RCV_MA]);
    for (int i = 0; i < EVT_W; i++) begin
      next_r.reason[i] = w1c(r.reason[i], ev[i],
        wr_acc && i_paddr == ADDR_REASON && i_pwdata[i]);
    end
    if (i_psel && !i_penable) begin
      next_r.prdata = '0;
      case (i_paddr)
        ADDR_CMD_STATUS: begin
          next_r.prdata[BIT_SERR_EN]  = r.serr_en;
          next_r.prdata[BIT_SIG_TA]   = r.sig_ta;
          next_r.prdata[BIT_SIG_SERR] = r.sig_serr;
        end
        ADDR_BRIDGE_CTL: begin
          next_r.prdata[BIT_FWD_EN]  = r.fwd_en;
          next_r.prdata[BIT_MA_MODE] = r.ma_mode;
          next_r.prdata[BIT_MTO_EN]  = r.mto_en;
        end
        ADDR_SEC_STATUS: begin
          next_r.prdata[BIT_RCV_TA]   = r.rcv_ta;
          next_r.prdata[BIT_RCV_MA]   = r.rcv_ma;
          next_r.prdata[BIT_RCV_SERR] = r.rcv_serr;
        end
        ADDR_EVT_DIS: next_r.prdata[DIS_W-1:0] = r.dis;
        ADDR_REASON:  next_r.prdata[EVT_W-1:0] = r.reason;
        ADDR_LOCK_STAT: next_r.prdata[4:0] = {r.lock_drv, r.first, r.fsm};
        default: next_r.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      r        <= '0;
      r.fsm    <= LK_IDLE;
      r.serr_n <= 1'b1;
      r.s_serr_seen <= 1'b0;
      r.dis    <= DIS_RST;
      r.reason <= REASON_RST;
    end else begin
      r <= next_r;
    end
  end

  assign o_pready  = r.pready;
  assign o_prdata  = r.prdata;
  assign o_pslverr = r.pslverr;
  assign o_primary_system_error_out_n = r.serr_n;
  // open drain style: drive low only while the lock is held
  assign o_s_lock_out  = 1'b0;
  assign o_s_lock_oe   = r.lock_drv;
  assign o_tgt_retry   = r.tgt_retry;
  assign o_tgt_abort   = r.tgt_abort;
  assign o_read_return = r.read_return;
  assign o_queue_hold  = r.hold;
  assign o_fwd_locked  = r.flk;
  assign o_no_prefetch = r.lock_drv;
  assign o_up_unlocked = r.up_unlocked;
  assign o_lrd_start   = r.lrd_start;
  assign o_lrd_addr    = r.addr;
  assign o_lrd_cmd     = r.cmd;
  assign o_lrd_be      = r.be;
  assign o_lrd_par     = r.par;
  assign o_pw_discard  = r.pw_disc;
  assign o_dw_discard  = r.dw_disc;
  assign o_dr_discard  = r.dr_disc;
  assign o_lrd_discard = r.lrd_disc;

endmodule

`default_nettype wire

// ==== blsr_core_asserts.sv ====
`default_nettype none
module blsr_core_checker (
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_lock_req,
  input wire logic        i_lock_req_read,
  input wire logic        i_up_req,
  input wire logic        i_prior_empty,
  input wire logic        i_master_timeout,
  input wire logic        i_lpw_end,
  input wire logic        i_sec_retry,
  input wire logic [31:0] i_req_addr,
  input wire logic [31:0] o_lrd_addr,
  input wire logic        o_pready,
  input wire logic        o_tgt_retry,
  input wire logic        o_queue_hold,
  input wire logic        o_fwd_locked,
  input wire logic        o_no_prefetch,
  input wire logic        o_up_unlocked,
  input wire logic        o_lrd_start,
  input wire logic        o_s_lock_oe,
  input wire logic        o_lrd_discard
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_apb_answer: assert property (i_psel && !i_penable |=> o_pready ##1 !o_pready)
    else $error("apb answer late or long");
  a_up_unlocked: assert property (i_up_req |=> o_up_unlocked)
    else $error("upstream request not forwarded");
  a_lock_capture: assert property (i_lock_req && i_lock_req_read && !o_queue_hold
    |=> o_tgt_retry && o_lrd_addr == $past(i_req_addr)) else $error("lock capture wrong");
  a_nonread_drop: assert property (i_lock_req && !i_lock_req_read && !o_queue_hold
    |=> !o_queue_hold) else $error("write accepted as first lock");
  a_busy_retry: assert property (i_lock_req && o_queue_hold |=> o_tgt_retry)
    else $error("request not retried while held");
  a_start_prior: assert property (o_lrd_start |-> $past(i_prior_empty))
    else $error("locked read before queue drained");
  a_lock_sequence: assert property (o_lrd_start |-> !o_s_lock_oe ##1 o_s_lock_oe)
    else $error("lock sequence wrong");
  a_timeout_drop: assert property (i_master_timeout && o_s_lock_oe && !o_fwd_locked
    |=> !o_s_lock_oe && o_lrd_discard) else $error("timeout kept lock");
  a_retry_keep: assert property (o_fwd_locked && i_sec_retry |=> o_s_lock_oe)
    else $error("retry dropped held lock");
  a_lpw_release: assert property (o_fwd_locked && i_lpw_end |=> !o_s_lock_oe)
    else $error("lock kept after final write");
  a_no_prefetch: assert property (o_no_prefetch == o_s_lock_oe)
    else $error("prefetch allowed in lock");
  c_locked: cover property (o_fwd_locked ##1 !o_s_lock_oe);
  c_discard: cover property (o_lrd_discard);
  c_start: cover property (o_lrd_start ##1 o_s_lock_oe);
endmodule
bind blsr_core blsr_core_checker u_chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel),
  .i_penable(i_penable), .i_lock_req(i_lock_req), .i_lock_req_read(i_lock_req_read),
  .i_up_req(i_up_req), .i_prior_empty(i_prior_empty), .i_master_timeout(i_master_timeout),
  .i_lpw_end(i_lpw_end), .i_sec_retry(i_sec_retry), .i_req_addr(i_req_addr),
  .o_lrd_addr(o_lrd_addr), .o_pready(o_pready), .o_tgt_retry(o_tgt_retry),
  .o_queue_hold(o_queue_hold), .o_fwd_locked(o_fwd_locked), .o_no_prefetch(o_no_prefetch),
  .o_up_unlocked(o_up_unlocked), .o_lrd_start(o_lrd_start), .o_s_lock_oe(o_s_lock_oe),
  .o_lrd_discard(o_lrd_discard));
`default_nettype wire

// ==== blsr_far_model.sv ====
`default_nettype none
module blsr_far_model (
  input  wire logic       i_clk,
  input  wire logic       i_start,
  input  wire logic       i_abort_mode,
  input  wire logic [2:0] i_delay,
  input  wire logic       i_other_lock,
  input  wire logic       i_oe,
  output logic            o_s_lock_n,
  output logic            o_s_frame_n,
  output logic            o_s_irdy_n,
  output logic            o_done,
  output logic            o_abort
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       ofr  = 1'b0;
  logic       olk  = 1'b0;
  logic       busy = 1'b0;
  logic [2:0] cnt  = 3'h0;
  // another initiator: frame first, lock a clock later
  always_ff @(posedge i_clk) begin
    ofr     <= i_other_lock;
    olk     <= ofr & i_other_lock;
    o_done  <= busy && cnt == 3'h0 && !i_abort_mode;
    o_abort <= busy && cnt == 3'h0 && i_abort_mode;
    if (i_start) begin
      busy <= 1'b1;
      cnt  <= i_delay;
    end else if (busy) begin
      busy <= (cnt != 3'h0);
      cnt  <= cnt - 3'h1;
    end
  end
  // wire levels: pull-ups win when nobody drives
  assign o_s_frame_n = !(ofr | busy);
  assign o_s_lock_n  = !(olk | i_oe);
  assign o_s_irdy_n  = !busy;
endmodule
`default_nettype wire

// ==== blsr_sync.sv ====
`default_nettype none

package blsr_pkg;
  // pin sampler width and bit order
  localparam int unsigned SYNC_W      = 6;
  localparam int unsigned PIN_S_SERR  = 0;
  localparam int unsigned PIN_P_LOCK  = 1;
  localparam int unsigned PIN_P_FRAME = 2;
  localparam int unsigned PIN_S_LOCK  = 3;
  localparam int unsigned PIN_S_FRAME = 4;
  localparam int unsigned PIN_S_IRDY  = 5;

  // register byte addresses
  localparam logic [7:0] ADDR_CMD_STATUS = 8'h00;
  localparam logic [7:0] ADDR_BRIDGE_CTL = 8'h04;
  localparam logic [7:0] ADDR_SEC_STATUS = 8'h08;
  localparam logic [7:0] ADDR_EVT_DIS    = 8'h0c;
  localparam logic [7:0] ADDR_REASON     = 8'h10;
  localparam logic [7:0] ADDR_LOCK_STAT  = 8'h14;

  // field positions
  localparam int unsigned BIT_SERR_EN   = 8;
  localparam int unsigned BIT_SIG_TA    = 27;
  localparam int unsigned BIT_SIG_SERR  = 30;
  localparam int unsigned BIT_FWD_EN    = 1;
  localparam int unsigned BIT_MA_MODE   = 5;
  localparam int unsigned BIT_MTO_EN    = 11;
  localparam int unsigned BIT_RCV_TA    = 12;
  localparam int unsigned BIT_RCV_MA    = 13;
  localparam int unsigned BIT_RCV_SERR  = 14;
  localparam int unsigned EVT_W         = 7;
  localparam int unsigned DIS_W         = 5;

  // event order in the reason register
  localparam int unsigned EV_SEC_SERR = 0;
  localparam int unsigned EV_PW_TA    = 1;
  localparam int unsigned EV_PW_MA    = 2;
  localparam int unsigned EV_PW_DISC  = 3;
  localparam int unsigned EV_DW_DISC  = 4;
  localparam int unsigned EV_DR_DISC  = 5;
  localparam int unsigned EV_MTO      = 6;

  localparam int unsigned CNT_W            = 25;
  localparam int unsigned RETRY_LIMIT_DFLT = 16777216;

  localparam logic [EVT_W-1:0] REASON_RST = 7'h00;
  localparam logic [DIS_W-1:0] DIS_RST    = 5'h00;

  typedef enum logic [2:0] {
    LK_IDLE    = 3'b000,
    LK_QUEUED  = 3'b001,
    LK_WAITBUS = 3'b010,
    LK_ADDR    = 3'b011,
    LK_DATA    = 3'b100,
    LK_SECLK   = 3'b101,
    LK_LOCKED  = 3'b110,
    LK_ABORTED = 3'b111
  } blsr_lock_type;
endpackage

module blsr_sync
  import blsr_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire logic [SYNC_W-1:0] i_pins,
  input  wire logic [SYNC_W-1:0] i_rst_val,
  output logic      [SYNC_W-1:0] o_stable
);
  typedef struct packed {
    logic [SYNC_W-1:0] ff1;
    logic [SYNC_W-1:0] ff2;
    logic [SYNC_W-1:0] ff3;
    logic [SYNC_W-1:0] stable;
  } blsr_sync_type;

  blsr_sync_type r;
  blsr_sync_type next_r;

  always_comb begin
    next_r = r;
    next_r.ff1 = i_pins;
    next_r.ff2 = r.ff1;
    next_r.ff3 = r.ff2;
    // only a level seen on two late stages counts
    for (int i = 0; i < SYNC_W; i++) begin
      if (r.ff2[i] == r.ff3[i]) begin
        next_r.stable[i] = r.ff3[i];
      end
    end
  end

  // pins idle high; the reset value comes in as a constant from the parent
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      r <= '{ff1: i_rst_val, ff2: i_rst_val, ff3: i_rst_val, stable: i_rst_val};
    end else begin
      r <= next_r;
    end
  end

  assign o_stable = r.stable;
endmodule

`default_nettype wire

// ==== tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import blsr_pkg::*;
  localparam int LIMIT = 4;
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, addr = 32'h0;
  logic [3:0]  cmd = 4'h0, be = 4'h0, lcmd, lbe;
  logic [2:0]  dly = 3'h0;
  logic [13:0] ev = 14'h0;
  logic        rd = 1'b0, par = 1'b0, pe = 1'b0, pwl = 1'b0, mab = 1'b0;
  logic        sserr = 1'b1, plk = 1'b1, oth = 1'b0, pfr = 1'b1, pwp = 1'b0;
  logic        pready, pslverr, serr_n, oe, tretry, tabort, rret, hold, fwl, nopf, upu, lpar;
  logic        lstart, pwd, dwd, drd, lrdd, slk_n, sfr_n, sirdy_n, mdone, mabort, slv, hit;
  logic [31:0] prdata, laddr, rdat, cfg;
  int          err_count = 0, cmp_count = 0, seed = 47943, k, b;

  blsr_core #(.RETRY_LIMIT(LIMIT)) uut (
    .i_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_secondary_system_error_in_n(sserr), .i_p_lock_n(plk),
    .i_p_frame_n(pfr), .i_s_lock_n(slk_n), .i_s_frame_n(sfr_n), .i_s_irdy_n(sirdy_n),
    .o_primary_system_error_out_n(serr_n), .o_s_lock_out(), .o_s_lock_oe(oe),
    .i_lock_req(ev[0]), .i_lock_req_read(rd), .i_up_req(ev[1]), .i_req_addr(addr),
    .i_req_cmd(cmd), .i_req_be(be), .i_req_par(par), .i_rep_valid(ev[2]),
    .i_prior_empty(pe), .i_pw_pending(pwp), .i_sec_data_done(mdone), .i_sec_retry(ev[3]),
    .i_sec_abort(mabort), .i_sec_abort_master(mab), .i_master_timeout(ev[4]),
    .i_lpw_end(ev[5]), .i_pw_retry(ev[8]), .i_pw_done(ev[9]), .i_pw_target_abort(ev[6]),
    .i_pw_master_abort(ev[7]), .i_pw_locked(pwl), .i_dw_retry(ev[10]), .i_dw_done(ev[11]),
    .i_dr_retry(ev[12]), .i_dr_done(ev[13]), .o_tgt_retry(tretry), .o_tgt_abort(tabort),
    .o_read_return(rret), .o_queue_hold(hold), .o_fwd_locked(fwl), .o_no_prefetch(nopf),
    .o_up_unlocked(upu), .o_lrd_start(lstart), .o_lrd_addr(laddr), .o_lrd_cmd(lcmd),
    .o_lrd_be(lbe), .o_lrd_par(lpar), .o_pw_discard(pwd), .o_dw_discard(dwd),
    .o_dr_discard(drd), .o_lrd_discard(lrdd));

  blsr_far_model u_far (.i_clk(clk), .i_start(lstart), .i_abort_mode(mab), .i_delay(dly),
    .i_other_lock(oth), .i_oe(oe), .o_s_lock_n(slk_n), .o_s_frame_n(sfr_n),
    .o_s_irdy_n(sirdy_n), .o_done(mdone), .o_abort(mabort));

  initial forever #25 clk = ~clk;

  task automatic end_of_test();
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  // outputs are read at the edge, before that edge's updates land
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    slv  = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic pulse(input int n);
    @(posedge clk);
    ev[n] <= 1'b1;
    @(posedge clk);
    ev[n] <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_for(input int w, input int n, output logic h);
    h = 1'b0;
    for (int i = 0; i < n && !h; i++) begin
      @(posedge clk);
      h = (w == 0) ? !serr_n : (w == 1) ? lstart : (w == 2) ? !oe : (mdone | mabort);
    end
  endtask

  function automatic logic exp_serr(input int e, input logic [31:0] c);
    if (!c[0]) return 1'b0;
    if (e == 4) return c[2];
    if (e == 6) return c[8] | !c[3];
    return c[1] & (c[8] | !c[4]);
  endfunction

  task automatic lock_go(input logic ab, input logic full);
    @(posedge clk);
    plk  <= 1'b0;
    rd   <= 1'b1;
    pe   <= 1'b0;
    mab  <= ab;
    dly  <= 3'($random(seed));
    addr <= $random(seed);
    cmd  <= 4'($random(seed));
    be   <= 4'($random(seed));
    par  <= 1'($random(seed));
    oth  <= 1'b1;
    pulse(0);
    chk1(tretry, 1'b1);
    chk32(laddr, addr);
    chk32({23'h0, lcmd, lbe, lpar}, {23'h0, cmd, be, par});
    pulse(0);
    chk1(tretry, 1'b1);
    wait_for(1, 6, hit);
    chk1(hit, 1'b0);
    pe  <= 1'b1;
    wait_for(1, 10, hit);
    chk1(hit, 1'b0);
    oth <= 1'b0;
    wait_for(1, 20, hit);
    chk1(hit, 1'b1);
    wait_for(3, 20, hit);
    if (!full) return;
    pulse(2);
    if (ab) chk1(tabort, 1'b1);
    else chk1(rret, 1'b1);
    chk1(fwl, !ab);
  endtask

  initial begin
    repeat (10000) @(posedge clk);
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, 8'h18, 32'h0);
    chk1(slv, 1'b1);
    // random enables and disables against the three direct serr events
    for (int i = 0; i < 12; i++) begin
      cfg = $random(seed);
      k = (i % 3 == 0) ? 4 : (i % 3 == 1) ? 6 : 7;
      b = (k == 4) ? EV_MTO : (k == 6) ? EV_PW_TA : EV_PW_MA;
      apb(1'b1, ADDR_CMD_STATUS, (32'(cfg[0]) << BIT_SERR_EN) | (32'h1 << BIT_SIG_SERR));
      apb(1'b1, ADDR_BRIDGE_CTL, (32'(cfg[1]) << BIT_MA_MODE) | (32'(cfg[2]) << BIT_MTO_EN));
      apb(1'b1, ADDR_EVT_DIS, 32'(cfg[7:3]));
      pwl <= cfg[8];
      pulse(k);
      chk1(serr_n, !exp_serr(k, cfg));
      apb(1'b0, ADDR_CMD_STATUS, 32'h0);
      chk1(rdat[BIT_SIG_SERR], exp_serr(k, cfg));
      apb(1'b0, ADDR_REASON, 32'h0);
      chk32(rdat, exp_serr(k, cfg) ? (32'h1 << b) : 32'h0);
      apb(1'b1, ADDR_REASON, 32'h7f);
    end
    apb(1'b1, ADDR_CMD_STATUS, 32'h1 << BIT_SERR_EN);
    apb(1'b1, ADDR_BRIDGE_CTL, (32'h1 << BIT_FWD_EN) | (32'h1 << BIT_MTO_EN));
    apb(1'b1, ADDR_EVT_DIS, 32'h0);
    sserr <= 1'b0;
    wait_for(0, 12, hit);
    chk1(hit, 1'b1);
    sserr <= 1'b1;
    apb(1'b0, ADDR_SEC_STATUS, 32'h0);
    chk1(rdat[BIT_RCV_SERR], 1'b1);
    for (int j = 0; j < 3; j++) begin
      k = 8 + 2 * j;
      repeat (1 + ($random(seed) & 1)) pulse(k);
      pulse(k + 1);
      for (int r = 1; r <= LIMIT; r++) begin
        pulse(k);
        chk1((j == 0) ? pwd : (j == 1) ? dwd : drd, r == LIMIT);
        chk1(serr_n, r != LIMIT);
      end
    end
    rd <= 1'b0;
    pulse(0);
    chk1(hold, 1'b0);
    lock_go(1'b0, 1'b1);
    pulse(3);
    chk1(oe, 1'b1);
    pulse(1);
    chk1(upu, 1'b1);
    pfr <= 1'b0;
    plk <= 1'b1;
    wait_for(2, 8, hit);
    chk1(hit, 1'b0);
    pfr <= 1'b1;
    wait_for(2, 12, hit);
    chk1(hit, 1'b1);
    lock_go(1'b0, 1'b1);
    pwp <= 1'b1;
    plk <= 1'b1;
    wait_for(2, 8, hit);
    chk1(hit, 1'b0);
    pulse(5);
    chk1(oe, 1'b0);
    pwp <= 1'b0;
    lock_go(1'b0, 1'b0);
    pulse(4);
    chk1(lrdd, 1'b1);
    chk1(oe, 1'b0);
    lock_go(1'b1, 1'b1);
    plk <= 1'b1;
    apb(1'b0, ADDR_SEC_STATUS, 32'h0);
    chk1(rdat[BIT_RCV_MA], 1'b1);
    chk1(hold, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
